// ### rtl/pupwi_top.sv
`timescale 1ns/1ps
`default_nettype none
module pupwi_top
#(
   parameter int WRITE_INHIBIT_CYC = pupwi_pkg::WRITE_INHIBIT_CYCLES
)
(
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire logic supply_ok_i,
   input wire pupwi_pkg::pupwi_instr_t instr_i,
   input wire logic busy_i,
   input wire logic op_done_i,
   input wire pupwi_pkg::pupwi_bus_req_t bus_i,
   output logic [pupwi_pkg::DATA_W-1:0] rdata_o,
   output pupwi_pkg::pupwi_instr_t exec_o,
   output logic wel_o,
   output logic standby_o,
   output logic read_allowed_o,
   output logic write_allowed_o
);
   import pupwi_pkg::*;

   // tick limits for both timers
   localparam logic [CNT_W-1:0] SEL_LIMIT = CNT_W'(SELECT_DELAY_TICKS);
   localparam logic [CNT_W-1:0] WR_LIMIT =
      CNT_W'((WRITE_INHIBIT_CYC + TICK_CYCLES - 1) / TICK_CYCLES);

   logic supply_s; // synchronised supply-above-threshold level
   logic held; // power-on reset condition
   logic sel_done; // select delay elapsed
   logic wr_done; // write inhibit delay elapsed
   logic accept; // instruction taken this cycle
   pupwi_core_t core_reg; // registered core state
   pupwi_core_t core_next; // next core state

   // write-type instructions, all gated by the inhibit delay
   function automatic logic is_write_type(input pupwi_cmd_t kind);
      is_write_type = (kind == CMD_WRITE_ENABLE) || (kind == CMD_PAGE_PROGRAM) ||
                      (kind == CMD_SECTOR_ERASE) || (kind == CMD_BULK_ERASE) ||
                      (kind == CMD_STATUS_WRITE);
   endfunction : is_write_type

   // program and erase, which need the latch
   function automatic logic needs_latch(input pupwi_cmd_t kind);
      needs_latch = (kind == CMD_PAGE_PROGRAM) || (kind == CMD_SECTOR_ERASE) ||
                    (kind == CMD_BULK_ERASE);
   endfunction : needs_latch

   // status byte layout
   function automatic logic [7:0] status_byte(input logic write_enable_latch, input logic busy);
      status_byte = STATUS_RESET;
      status_byte[STAT_WEL_BIT] = write_enable_latch;
      status_byte[STAT_BUSY_BIT] = busy;
   endfunction : status_byte

   // supply detector comes from outside the clock domain
   pupwi_sync u_supply_sync
   (
      .core_clk_i(core_clk_i),
      .rstn_i(rstn_i),
      .async_i(supply_ok_i),
      .sync_o(supply_s)
   );

   assign held = !supply_s;

   // select delay timer, restarted by every reset condition
   pupwi_timer u_select_timer
   (
      .core_clk_i(core_clk_i),
      .rstn_i(rstn_i),
      .clear_i(held),
      .limit_i(SEL_LIMIT),
      .done_o(sel_done)
   );

   // write inhibit timer, restarted by every reset condition
   pupwi_timer u_inhibit_timer
   (
      .core_clk_i(core_clk_i),
      .rstn_i(rstn_i),
      .clear_i(held),
      .limit_i(WR_LIMIT),
      .done_o(wr_done)
   );

   // phase sequencing, instruction gating, latch and register port
   always_comb
   begin
      core_next = core_reg;
      core_next.exec = '{valid: 1'b0, kind: CMD_READ};
      core_next.rdata = '0;
      accept = 1'b0;
      // phase machine
      case (core_reg.state)
         ST_HELD:
         begin
            core_next.state = ST_WAIT;
            core_next.standby = 1'b1;
            core_next.write_enable_latch = 1'b0;
         end
         ST_WAIT:
         begin
            if (sel_done && wr_done)
            begin
               core_next.state = ST_READY;
            end
            else if (sel_done)
            begin
               core_next.state = ST_READ_ONLY;
            end
         end
         ST_READ_ONLY:
         begin
            if (wr_done)
            begin
               core_next.state = ST_READY;
            end
         end
         ST_READY:
         begin
            core_next.state = ST_READY;
         end
         default:
         begin
            core_next.state = ST_HELD;
         end
      endcase
      // instruction gating
      if (instr_i.valid && (core_reg.state != ST_HELD))
      begin
         if (is_write_type(instr_i.kind))
         begin
            // inhibit delay, software hold-off and latch check
            accept = (core_reg.state == ST_READY) && !core_reg.lock &&
                     (!needs_latch(instr_i.kind) || core_reg.write_enable_latch);
         end
         else
         begin
            accept = (core_reg.state == ST_READ_ONLY) || (core_reg.state == ST_READY);
         end
         if (accept)
         begin
            core_next.exec = instr_i;
         end
         else if (core_reg.discards != 16'hFFFF)
         begin
            core_next.discards = core_reg.discards + 16'h0001;
         end
      end
      // latch: clear on write disable or finished cycle, set wins
      if (accept && (instr_i.kind == CMD_WRITE_DISABLE))
      begin
         core_next.write_enable_latch = 1'b0;
      end
      else if (op_done_i)
      begin
         core_next.write_enable_latch = 1'b0;
      end
      if (accept && (instr_i.kind == CMD_WRITE_ENABLE))
      begin
         core_next.write_enable_latch = 1'b1;
      end
      // standby once powered and idle
      if (core_reg.state != ST_HELD)
      begin
         core_next.standby = !busy_i && !core_next.exec.valid;
      end
      // register writes
      if (bus_i.wr)
      begin
         if (bus_i.addr == REG_CTRL)
         begin
            core_next.lock = bus_i.wdata[CTRL_LOCK_BIT];
         end
         else if (bus_i.addr == REG_DISCARDS)
         begin
            core_next.discards = DISCARDS_RESET;
         end
      end
      // register reads, answered in the next cycle only
      if (bus_i.rd)
      begin
         if (bus_i.addr == REG_CTRL)
         begin
            core_next.rdata[CTRL_LOCK_BIT] = core_reg.lock;
         end
         else if (bus_i.addr == REG_STATUS)
         begin
            core_next.rdata[7:0] = status_byte(core_reg.write_enable_latch, busy_i);
         end
         else if (bus_i.addr == REG_PHASE)
         begin
            core_next.rdata[PHASE_STANDBY_BIT] = core_reg.standby;
            core_next.rdata[PHASE_READ_BIT] = read_allowed_o;
            core_next.rdata[PHASE_WRITE_BIT] = write_allowed_o;
            core_next.rdata[PHASE_STATE_LSB +: 4] = core_reg.state;
         end
         else if (bus_i.addr == REG_DISCARDS)
         begin
            core_next.rdata[CNT_W-1:0] = core_reg.discards;
         end
         else if (bus_i.addr == REG_BLANK)
         begin
            core_next.rdata[7:0] = ERASED_BYTE;
         end
      end
      // power-on reset overrides everything, also on power-down
      if (held)
      begin
         core_next = CORE_RESET;
         accept = 1'b0;
      end
   end

   // register the core state
   always_ff @(posedge core_clk_i)
   begin
      if (!rstn_i)
      begin
         core_reg <= CORE_RESET;
      end
      else
      begin
         core_reg <= core_next;
      end
   end

   // outputs from registers; the two gate flags are decoded from state and lock
   assign rdata_o = core_reg.rdata;
   assign exec_o = core_reg.exec;
   assign wel_o = core_reg.write_enable_latch;
   assign standby_o = core_reg.standby;
   assign read_allowed_o = (core_reg.state == ST_READ_ONLY) || (core_reg.state == ST_READY);
   assign write_allowed_o = (core_reg.state == ST_READY) && !core_reg.lock;

   // cycles since the supply came up, for timing checks
   logic [CNT_W-1:0] up_cnt;
   always_ff @(posedge core_clk_i)
   begin
      if (!rstn_i || held)
      begin
         up_cnt <= '0;
      end
      else if (up_cnt != 16'hFFFF)
      begin
         up_cnt <= up_cnt + 16'h0001;
      end
   end

   held_quiet_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      held |=> (core_reg.state == ST_HELD) && !exec_o.valid && !wel_o)
      else $error("activity while power-on reset held");

   early_write_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      instr_i.valid && is_write_type(instr_i.kind) && !write_allowed_o |=> !exec_o.valid)
      else $error("write-type instruction taken during inhibit");

   inhibit_time_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      $rose(write_allowed_o) && !core_reg.lock |-> up_cnt > CNT_W'(WR_LIMIT * TICK_CYCLES))
      else $error("write allowed before inhibit delay");

   select_time_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      $rose(read_allowed_o) |-> up_cnt > CNT_W'(SELECT_DELAY_TICKS * TICK_CYCLES))
      else $error("reads allowed before select delay");

   early_read_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      (core_reg.state == ST_READ_ONLY) && supply_s && instr_i.valid &&
      (instr_i.kind == CMD_READ) |=> exec_o.valid && (exec_o.kind == CMD_READ))
      else $error("read refused after select delay");

   powerup_state_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      (core_reg.state == ST_HELD) && supply_s |=> standby_o && !wel_o)
      else $error("power-up not standby with latch clear");

   powerdown_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      (core_reg.state == ST_READY) && held |=> !read_allowed_o ##1 !exec_o.valid)
      else $error("operations still enabled after supply drop");

   status_blank_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      bus_i.rd && (bus_i.addr == REG_STATUS) && !wel_o && !busy_i && supply_s
      |=> rdata_o == 32'h0000_0000)
      else $error("status not zero in delivered state");

   latch_gate_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      instr_i.valid && needs_latch(instr_i.kind) && !wel_o |=> !exec_o.valid)
      else $error("program or erase taken without latch");

   latch_set_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      instr_i.valid && (instr_i.kind == CMD_WRITE_ENABLE) && write_allowed_o && supply_s
      |=> wel_o && exec_o.valid)
      else $error("write enable did not set latch");

   reach_read_c: cover property (@(posedge core_clk_i) disable iff (!rstn_i)
      core_reg.state == ST_READ_ONLY);
   reach_ready_c: cover property (@(posedge core_clk_i) disable iff (!rstn_i)
      $rose(write_allowed_o));
   discard_c: cover property (@(posedge core_clk_i) disable iff (!rstn_i)
      instr_i.valid && is_write_type(instr_i.kind) && read_allowed_o && !write_allowed_o);
   drop_c: cover property (@(posedge core_clk_i) disable iff (!rstn_i)
      (core_reg.state == ST_READY) && held);

endmodule : pupwi_top
`default_nettype wire

// ### rtl/pupwi_pkg.sv
package pupwi_pkg;

   // clock and time base
   localparam int CLK_PERIOD_NS = 20; // 50 MHz core clock
   localparam int TICK_NS = 1000; // internal time base tick, 1 us
   localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // select delay after supply minimum, least time, rounded up
   localparam int SELECT_DELAY_US = 60;
   localparam int SELECT_DELAY_CYCLES = (SELECT_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SELECT_DELAY_TICKS = (SELECT_DELAY_CYCLES + TICK_CYCLES - 1) / TICK_CYCLES;

   // write inhibit delay window; the device holds off for the least figure
   localparam int WRITE_INHIBIT_MIN_MS = 1;
   localparam int WRITE_INHIBIT_MAX_MS = 10;
   localparam int WRITE_INHIBIT_CYCLES =
      (WRITE_INHIBIT_MIN_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // widths
   localparam int PRESC_W = 6; // holds TICK_CYCLES - 1
   localparam int CNT_W = 16; // tick counter width
   localparam int ADDR_W = 8; // register byte address
   localparam int DATA_W = 32; // register data

   // register byte offsets
   localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
   localparam logic [ADDR_W-1:0] REG_PHASE = 8'h08;
   localparam logic [ADDR_W-1:0] REG_DISCARDS = 8'h0C;
   localparam logic [ADDR_W-1:0] REG_BLANK = 8'h10;

   // field positions
   localparam int CTRL_LOCK_BIT = 0; // software write hold-off
   localparam int STAT_BUSY_BIT = 0; // write in progress
   localparam int STAT_WEL_BIT = 1; // write enable latch
   localparam int PHASE_STANDBY_BIT = 0;
   localparam int PHASE_READ_BIT = 1;
   localparam int PHASE_WRITE_BIT = 2;
   localparam int PHASE_STATE_LSB = 4;

   // reset and delivery values
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   localparam logic [CNT_W-1:0] DISCARDS_RESET = 16'h0000;

   // decoded instruction kinds, one-hot
   typedef enum logic [6:0] {
      CMD_READ = 7'h01,
      CMD_WRITE_ENABLE = 7'h02,
      CMD_WRITE_DISABLE = 7'h04,
      CMD_PAGE_PROGRAM = 7'h08,
      CMD_SECTOR_ERASE = 7'h10,
      CMD_BULK_ERASE = 7'h20,
      CMD_STATUS_WRITE = 7'h40
   } pupwi_cmd_t;

   // power-up phases, one-hot
   typedef enum logic [3:0] {
      ST_HELD = 4'h1,
      ST_WAIT = 4'h2,
      ST_READ_ONLY = 4'h4,
      ST_READY = 4'h8
   } pupwi_state_t;

   // decoded instruction carrier
   typedef struct packed {
      logic valid;
      pupwi_cmd_t kind;
   } pupwi_instr_t;

   // register port request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } pupwi_bus_req_t;

   // whole state of the sequencer core
   typedef struct packed {
      pupwi_state_t state;
      logic write_enable_latch;
      logic standby;
      logic lock;
      logic [CNT_W-1:0] discards;
      pupwi_instr_t exec;
      logic [DATA_W-1:0] rdata;
   } pupwi_core_t;

   localparam pupwi_core_t CORE_RESET = '{
      state: ST_HELD,
      write_enable_latch: 1'b0,
      standby: 1'b0,
      lock: 1'b0,
      discards: DISCARDS_RESET,
      exec: '{valid: 1'b0, kind: CMD_READ},
      rdata: 32'h0000_0000
   };

endpackage : pupwi_pkg

// ### rtl/pupwi_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pupwi_sync
(
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire logic async_i,
   output logic sync_o
);
   import pupwi_pkg::*;

   // two stage synchroniser state
   typedef struct packed {
      logic meta;
      logic level;
   } pupwi_sync_t;

   pupwi_sync_t sync_reg; // registered stages
   pupwi_sync_t sync_next; // next stages

   // shift the pin through both stages; only level is read outside
   always_comb
   begin
      sync_next.meta = async_i;
      sync_next.level = sync_reg.meta;
   end

   // register, cleared to the unpowered level
   always_ff @(posedge core_clk_i)
   begin
      if (!rstn_i)
      begin
         sync_reg <= '0;
      end
      else
      begin
         sync_reg <= sync_next;
      end
   end

   assign sync_o = sync_reg.level;

endmodule : pupwi_sync
`default_nettype wire

// ### rtl/pupwi_timer.sv
`timescale 1ns/1ps
`default_nettype none
module pupwi_timer
(
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire logic clear_i,
   input wire logic [pupwi_pkg::CNT_W-1:0] limit_i,
   output logic done_o
);
   import pupwi_pkg::*;

   localparam logic [PRESC_W-1:0] PRESC_LAST = PRESC_W'(TICK_CYCLES - 1);

   // prescaler, tick counter and done flag
   typedef struct packed {
      logic [PRESC_W-1:0] presc;
      logic [CNT_W-1:0] count;
      logic done;
   } pupwi_timer_t;

   pupwi_timer_t tmr_reg; // registered timer
   pupwi_timer_t tmr_next; // next timer

   // count time base ticks until the limit, then hold
   always_comb
   begin
      tmr_next = tmr_reg;
      if (clear_i)
      begin
         tmr_next = '0;
      end
      else if (tmr_reg.count != limit_i)
      begin
         if (tmr_reg.presc == PRESC_LAST)
         begin
            tmr_next.presc = '0;
            tmr_next.count = tmr_reg.count + 16'h0001;
         end
         else
         begin
            tmr_next.presc = tmr_reg.presc + 6'h01;
         end
      end
      // flag stays set while the count sits at the limit
      tmr_next.done = !clear_i && (tmr_reg.count == limit_i);
   end

   // register the timer
   always_ff @(posedge core_clk_i)
   begin
      if (!rstn_i)
      begin
         tmr_reg <= '0;
      end
      else
      begin
         tmr_reg <= tmr_next;
      end
   end

   assign done_o = tmr_reg.done;

endmodule : pupwi_timer
`default_nettype wire

// ### testbench/pupwi_host.sv
`timescale 1ns/1ps
`default_nettype none
// host side: hands decoded instructions to the device
module pupwi_host
(
   input wire logic core_clk_i,
   input wire logic supply_ok_i,
   input wire logic write_allowed_i,
   output var pupwi_pkg::pupwi_instr_t instr_o
);
   import pupwi_pkg::*;

   // idle: no instruction
   initial instr_o = '{valid: 1'b0, kind: CMD_READ};

   // one-cycle instruction pulse; force_it breaks host manners on purpose
   task automatic send(input pupwi_cmd_t kind, input bit force_it, output bit sent);
      begin
         // deselected while supply is down
         // write-type held back until inhibit ends
         sent = force_it || (supply_ok_i &&
            (write_allowed_i || kind inside {CMD_READ, CMD_WRITE_DISABLE}));
         @(posedge core_clk_i);
         instr_o <= '{valid: sent, kind: kind};
         @(posedge core_clk_i);
         instr_o <= '{valid: 1'b0, kind: kind};
      end
   endtask : send
endmodule : pupwi_host
`default_nettype wire

// ### testbench/power_up_write_inhibit_bench.sv
`timescale 1ns/1ps
`default_nettype none
// self-checking bench with a behavioural model of the gating
module power_up_write_inhibit_bench;
   import pupwi_pkg::*;
   localparam int INH = 4000; // shortened inhibit delay, cycles
   logic core_clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic supply_ok_i = 1'b1;
   logic busy_i = 1'b0;
   logic op_done_i = 1'b0;
   pupwi_bus_req_t bus_i = '0;
   pupwi_instr_t instr_i;
   pupwi_instr_t exec_o;
   logic [DATA_W-1:0] rdata_o;
   logic wel_o, standby_o, read_allowed_o, write_allowed_o;
   int bad_count = 0;
   int comparisons = 0;
   int cyc = 0;
   int t0, n, m_disc;
   bit m_rd, m_wr, m_wel;
   pupwi_cmd_t kinds [7] = '{CMD_READ, CMD_WRITE_ENABLE, CMD_WRITE_DISABLE,
      CMD_PAGE_PROGRAM, CMD_SECTOR_ERASE, CMD_BULK_ERASE, CMD_STATUS_WRITE};

   pupwi_top #(.WRITE_INHIBIT_CYC(INH)) u_dut (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
      .supply_ok_i(supply_ok_i), .instr_i(instr_i), .busy_i(busy_i),
      .op_done_i(op_done_i), .bus_i(bus_i), .rdata_o(rdata_o), .exec_o(exec_o),
      .wel_o(wel_o), .standby_o(standby_o), .read_allowed_o(read_allowed_o),
      .write_allowed_o(write_allowed_o));

   pupwi_host u_host (.core_clk_i(core_clk_i), .supply_ok_i(supply_ok_i),
      .write_allowed_i(write_allowed_o), .instr_o(instr_i));

   // clock
   always #10 core_clk_i = ~core_clk_i;

   // cycle count and hang guard
   always @(posedge core_clk_i)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         bad_count = bad_count + 1;
         give_verdict();
      end
   end

   // verdict and end of run
   task automatic give_verdict();
      begin
         if (bad_count == 0 && comparisons > 0)
            $display("Test passed");
         else
            $display("Test failed");
         $finish;
      end
   endtask : give_verdict

   // single comparison point
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      begin
         comparisons = comparisons + 1;
         if (seen !== exp)
         begin
            bad_count = bad_count + 1;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
         end
      end
   endtask : chk

   // register write, one strobe cycle
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      begin
         @(posedge core_clk_i);
         bus_i <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
         @(posedge core_clk_i);
         bus_i <= '0;
         #1;
      end
   endtask : reg_wr

   // register read, data taken in the cycle after the strobe
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      begin
         @(posedge core_clk_i);
         bus_i <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
         @(posedge core_clk_i);
         bus_i <= '0;
         #1;
         chk(rdata_o, exp);
      end
   endtask : rd_chk

   // send one instruction and compare with the model
   task automatic issue(input pupwi_cmd_t k, input bit f);
      bit ok, sent;
      begin
         ok = (k inside {CMD_READ, CMD_WRITE_DISABLE}) ? m_rd : m_wr;
         if (k inside {CMD_PAGE_PROGRAM, CMD_SECTOR_ERASE, CMD_BULK_ERASE})
            ok = ok && m_wel;
         u_host.send(k, f, sent);
         #1;
         ok = ok && sent;
         chk(exec_o.valid, ok);
         if (ok)
            chk(exec_o.kind, k);
         if (ok && k == CMD_WRITE_ENABLE)
            m_wel = 1'b1;
         if (ok && k == CMD_WRITE_DISABLE)
            m_wel = 1'b0;
         if (!ok && sent)
            m_disc = m_disc + 1;
         chk(wel_o, m_wel);
      end
   endtask : issue

   // cycles from t0 until a gate flag rises, bounded
   task automatic wait_up(input bit wr);
      begin
         while (((wr ? write_allowed_o : read_allowed_o) !== 1'b1) && cyc - t0 < 9000)
         begin
            @(posedge core_clk_i);
            #1;
         end
         n = cyc - t0;
      end
   endtask : wait_up

   // main sequence
   initial
   begin
      void'($urandom(50986));
      m_disc = 0;
      repeat (3) @(posedge core_clk_i);
      #1;
      chk(standby_o, 0);
      chk(read_allowed_o, 0);
      @(posedge core_clk_i);
      rstn_i <= 1'b1;
      #1;
      t0 = cyc;
      repeat (5) @(posedge core_clk_i);
      #1;
      chk(standby_o, 1);
      chk(wel_o, 0);
      rd_chk(REG_STATUS, 32'h0000_0000);
      rd_chk(REG_BLANK, 32'h0000_00FF);
      rd_chk(8'h14, 32'h0000_0000);
      issue(CMD_READ, 1'b1);
      issue(CMD_WRITE_ENABLE, 1'b1);
      wait_up(1'b0);
      chk(n >= 3000 && n <= 3012, 1);
      rd_chk(REG_PHASE, 32'h0000_0043);
      m_rd = 1'b1;
      for (int i = 1; i < 7; i++)
         if (i != 2)
            issue(kinds[i], 1'b1);
      issue(CMD_READ, 1'b0);
      rd_chk(REG_DISCARDS, m_disc);
      wait_up(1'b1);
      chk(n >= INH && n <= INH + 12, 1);
      rd_chk(REG_PHASE, 32'h0000_0087);
      m_wr = 1'b1;
      issue(CMD_PAGE_PROGRAM, 1'b0);
      issue(CMD_WRITE_ENABLE, 1'b0);
      rd_chk(REG_STATUS, 32'h0000_0002);
      issue(CMD_PAGE_PROGRAM, 1'b0);
      @(posedge core_clk_i);
      busy_i <= 1'b1;
      rd_chk(REG_STATUS, 32'h0000_0003);
      chk(standby_o, 0);
      @(posedge core_clk_i);
      op_done_i <= 1'b1;
      @(posedge core_clk_i);
      op_done_i <= 1'b0;
      busy_i <= 1'b0;
      m_wel = 1'b0;
      #1;
      chk(wel_o, 0);
      reg_wr(REG_CTRL, 32'h0000_0001);
      chk(write_allowed_o, 0);
      rd_chk(REG_CTRL, 32'h0000_0001);
      m_wr = 1'b0;
      issue(CMD_STATUS_WRITE, 1'b1);
      reg_wr(REG_CTRL, 32'h0000_0000);
      m_wr = 1'b1;
      repeat (40) issue(kinds[$urandom % 7], 1'b0);
      rd_chk(REG_DISCARDS, m_disc);
      issue(CMD_WRITE_ENABLE, 1'b0);
      @(posedge core_clk_i);
      supply_ok_i <= 1'b0;
      repeat (5) @(posedge core_clk_i);
      #1;
      chk({read_allowed_o, write_allowed_o, wel_o, standby_o}, 0);
      m_rd = 1'b0;
      m_wr = 1'b0;
      m_wel = 1'b0;
      issue(CMD_READ, 1'b1);
      rd_chk(REG_STATUS, 32'h0000_0000);
      @(posedge core_clk_i);
      supply_ok_i <= 1'b1;
      #1;
      t0 = cyc;
      wait_up(1'b1);
      chk(n >= INH && n <= INH + 12, 1);
      rd_chk(REG_DISCARDS, 32'h0000_0000);
      give_verdict();
   end
endmodule : power_up_write_inhibit_bench
`default_nettype wire
